// >>> design/eud_pkg.sv
// package for the enhanced uart: register map, field positions, counts, types
// assumes a single 200 MHz clock shared by bus, uart and the timer 1 overflow source
package eud_pkg;

  // ************************************************
  // register map (byte addresses, one word each)
  // ************************************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_BUF = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_PWR = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_DIVL = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_DIVH = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_CFG = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_RSRC = 5'h1C;

  // ************************************************
  // field positions
  // ************************************************
  localparam int B_SM0 = 7;
  localparam int B_SM1 = 6;
  localparam int B_REN = 4;
  localparam int B_TB8 = 3;
  localparam int B_RB8 = 2;
  localparam int B_TI = 1;
  localparam int B_RI = 0;
  localparam int B_DBL = 7;
  localparam int B_BRK = 3;
  localparam int B_FE = 2;
  localparam int B_HFULL = 1;
  localparam int B_BUSY = 0;
  localparam int B_RATE_DOUBLE_BIT = 7;
  localparam int B_FESEL = 6;
  localparam int B_BRGSEL = 0;
  localparam int B_BRKRST = 1;
  localparam int B_BRKSRC = 0;

  // ************************************************
  // counts and codes
  // ************************************************
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] PH_MID = 4'h7;
  localparam logic [3:0] PH_HIGH = 4'h8;
  localparam logic [3:0] NB_M0 = 4'h7;
  localparam logic [3:0] NB_8 = 4'h9;
  localparam logic [3:0] NB_9 = 4'hA;
  localparam logic [3:0] NINTH_POS = 4'h9;
  localparam logic [3:0] RX_NB_8 = 4'h7;
  localparam logic [3:0] RX_NB_9 = 4'h8;
  localparam logic [7:0] BRK_TICKS = 8'hB0;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {MODE_SHIFT, MODE_8, MODE_9F, MODE_9V} eud_mode_t;
  typedef enum {T_IDLE, T_FRAME, T_SHIFT0} eud_tst_t;
  typedef enum {R_IDLE, R_START, R_DATA, R_STOP} eud_rst_t;

  // software configuration gathered in one bundle
  typedef struct packed {
    eud_mode_t mode;
    logic ren;
    logic tb8;
    logic rate_double_bit;
    logic fe_sel;
    logic dbl;
    logic brg_sel;
    logic brk_rst_en;
  } eud_cfg_t;

  localparam eud_cfg_t CFG_RST = '0;

endpackage

// >>> design/eud_uart.sv
// enhanced uart with four modes, baud generator, break detect and tx double buffer
// assumes an axi4-lite master on aclk and a one-cycle timer 1 overflow pulse on aclk
//
// How it works
// - mode 0: data on rx line, clock on tx line, 8 bits lsb first, clk/16
// - 8-bit frame: low start, 8 data bits lsb first, high stop
// - 8-bit frame reception stores the stop bit in rx_ninth_bit
// - 8-bit frame rate from timer 1 overflow or baud generator
// - fixed 9-bit frame: start, 8 data, tx_ninth_bit, stop
// - 9-bit reception puts the ninth bit in rx_ninth_bit, drops stop
// - fixed 9-bit rate is clk/16 with rate doubling, else clk/32
// - mode 3 equals fixed 9-bit mode but rate from timer 1 or generator
// - baud generator uses a 16-bit divisor of two bytes, runs on clock
// - timer 1 rate halved again when rate doubling is clear
// - framing error in status; top control bit shows it when selected
// - break when receive line low for 11 bit times, reported in status
// - optional break-triggered reset of the whole device
// - double buffering sends back-to-back characters with one stop bit
// - double_buffer_enable is status bit 7; zero gives single buffering
// - double buffered: tx flag raised when holding buffer can accept
// - double buffered: tx_ninth_bit latched with the data byte
// - break reset sets a flag in reset_source_reg, cleared by writing zero
`timescale 1ns/1ps
module eud_uart
  import eud_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [eud_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [eud_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic t1_overflow,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_n,
  output logic txd_o,
  output logic device_reset
);
  import eud_pkg::*;

  // ************************************************
  // declarations
  // ************************************************
  eud_cfg_t cfg_q, cfg_d;
  logic ti_q, ti_d, ri_q, ri_d, rb8_q, rb8_d, fe_q, fe_d, brk_q, brk_d;
  logic brksrc_q, brksrc_d, devrst_q, devrst_d;
  logic [7:0] rbuf_q, rbuf_d, divl_q, divl_d, divh_q, divh_d;
  logic aw_q, aw_d, w_q, w_d, awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
  logic arr_q, arr_d, rv_q, rv_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wdat_q, wdat_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic wr_go, buf_wr;
  logic [15:0] brg_q, brg_d;
  logic half_q, half_d, os_tick;
  eud_tst_t tst_q, tst_d;
  logic [10:0] tsr_q, tsr_d;
  logic [3:0] tph_q, tph_d, tbit_q, tbit_d;
  logic t0rx_q, t0rx_d, hfull_q, hfull_d, txd_q, txd_d, rxo_q, rxo_d, rxoe_q, rxoe_d;
  logic [8:0] hold_q, hold_d;
  logic ti_set, m0_ri_set;
  eud_rst_t rst_q, rst_d;
  logic [3:0] rph_q, rph_d, rbit_q, rbit_d;
  logic [8:0] rsr_q, rsr_d;
  logic [7:0] bcnt_q, bcnt_d;
  logic rs1_q, rs2_q, rx_done, rx_nb8, rx_stop, brk_set;
  logic [7:0] rx_data;
  logic nine;

  assign nine = cfg_q.mode[1];

  // ************************************************
  // axi4-lite slave and register file
  // ************************************************
  // address and data may arrive in either order; write fires once both are held
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    waddr_d = waddr_q;
    wdat_d = wdat_q;
    bv_d = bv_q && !s_axi_bready;
    bresp_d = bresp_q;
    rv_d = rv_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && awr_q) begin
      aw_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q) begin
      w_d = 1'b1;
      wdat_d = s_axi_wstrb[0] ? s_axi_wdata : {24'h000000, 8'h00};
    end
    wr_go = aw_q && w_q && !bv_q;
    buf_wr = wr_go && waddr_q == OFF_BUF;
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = (waddr_q[1:0] == 2'h0 && waddr_q <= OFF_RSRC) ? RESP_OK : RESP_ERR;
    end
    awr_d = !aw_d && !bv_d;
    wr_d = !w_d && !bv_d;
    arr_d = !rv_d && !(s_axi_arvalid && arr_q);
    if (s_axi_arvalid && arr_q) begin
      rv_d = 1'b1;
      rresp_d = RESP_OK;
      rdata_d = 32'h00000000;
      unique case (s_axi_araddr)
        // frame error shown in top bit when the select is set, else mode bit 1 (SM0)
        OFF_CTRL: rdata_d[7:0] = {cfg_q.fe_sel ? fe_q : cfg_q.mode[1], cfg_q.mode[0], 1'b0,
                                  cfg_q.ren, cfg_q.tb8, rb8_q, ti_q, ri_q};
        OFF_BUF: rdata_d[7:0] = rbuf_q;
        OFF_STAT: rdata_d[7:0] = {cfg_q.dbl, 3'h0, brk_q, fe_q, hfull_q, tst_q != T_IDLE};
        OFF_PWR: rdata_d[7:0] = {cfg_q.rate_double_bit, cfg_q.fe_sel, 6'h00};
        OFF_DIVL: rdata_d[7:0] = divl_q;
        OFF_DIVH: rdata_d[7:0] = divh_q;
        OFF_CFG: rdata_d[7:0] = {6'h00, cfg_q.brk_rst_en, cfg_q.brg_sel};
        OFF_RSRC: rdata_d[7:0] = {7'h00, brksrc_q};
        default: rresp_d = RESP_ERR;
      endcase
    end
  end

  // software fields; hardware set always wins over a software clear
  always_comb begin
    cfg_d = cfg_q;
    divl_d = divl_q;
    divh_d = divh_q;
    ti_d = ti_q;
    ri_d = ri_q;
    rb8_d = rb8_q;
    fe_d = fe_q;
    brk_d = brk_q;
    brksrc_d = brksrc_q;
    rbuf_d = rbuf_q;
    if (wr_go) begin
      unique case (waddr_q)
        OFF_CTRL: begin
          // mode bit 1 (SM0) only writable while the select is clear
          if (!cfg_q.fe_sel) cfg_d.mode[1] = wdat_q[B_SM0];
          else if (!wdat_q[B_SM0]) fe_d = 1'b0;
          cfg_d.mode[0] = wdat_q[B_SM1];
          cfg_d.ren = wdat_q[B_REN];
          cfg_d.tb8 = wdat_q[B_TB8];
          rb8_d = wdat_q[B_RB8];
          ti_d = ti_q && wdat_q[B_TI];
          ri_d = ri_q && wdat_q[B_RI];
        end
        OFF_STAT: begin
          cfg_d.dbl = wdat_q[B_DBL];
          brk_d = brk_q && wdat_q[B_BRK];
          fe_d = fe_q && wdat_q[B_FE];
        end
        OFF_PWR: begin
          cfg_d.rate_double_bit = wdat_q[B_RATE_DOUBLE_BIT];
          cfg_d.fe_sel = wdat_q[B_FESEL];
        end
        OFF_DIVL: divl_d = wdat_q[7:0];
        OFF_DIVH: divh_d = wdat_q[7:0];
        OFF_CFG: begin
          cfg_d.brg_sel = wdat_q[B_BRGSEL];
          cfg_d.brk_rst_en = wdat_q[B_BRKRST];
        end
        OFF_RSRC: brksrc_d = brksrc_q && wdat_q[B_BRKSRC];
        default: ;
      endcase
    end
    if (ti_set) ti_d = 1'b1;
    if (m0_ri_set) begin
      ri_d = 1'b1;
      // last bit is still on its way into the shifter this cycle
      rbuf_d = {rs2_q, tsr_q[7:1]};
    end
    if (rx_done) begin
      ri_d = 1'b1;
      rbuf_d = rx_data;
      // ninth flag from stop or ninth data bit
      rb8_d = rx_nb8;
      if (!rx_stop) fe_d = 1'b1;
    end
    if (brk_set) brk_d = 1'b1;
    if (brk_set && cfg_q.brk_rst_en) brksrc_d = 1'b1;
  end

  // one-cycle whole-device reset request on break
  assign devrst_d = brk_set && cfg_q.brk_rst_en;

  // ************************************************
  // baud generation: one tick per sixteenth of a bit
  // ************************************************
  always_comb begin
    brg_d = brg_q + 16'h0001;
    half_d = half_q;
    os_tick = 1'b0;
    // 16-bit divisor on the core clock
    if (brg_q >= {divh_q, divl_q}) brg_d = DIV_RST;
    unique case (cfg_q.mode)
      MODE_SHIFT: os_tick = 1'b0;
      MODE_9F: begin
        half_d = !half_q;
        os_tick = cfg_q.rate_double_bit || half_q;
      end
      default: begin
        if (cfg_q.brg_sel) os_tick = brg_q >= {divh_q, divl_q};
        else if (t1_overflow) begin
          half_d = !half_q;
          os_tick = cfg_q.rate_double_bit || half_q;
        end
      end
    endcase
  end

  // ************************************************
  // transmitter and mode 0 shifter
  // ************************************************
  always_comb begin
    tst_d = tst_q;
    tsr_d = tsr_q;
    tph_d = tph_q;
    tbit_d = tbit_q;
    t0rx_d = t0rx_q;
    hold_d = hold_q;
    hfull_d = hfull_q;
    txd_d = 1'b1;
    rxo_d = 1'b1;
    rxoe_d = 1'b1;
    ti_set = 1'b0;
    m0_ri_set = 1'b0;
    // writes while the holder is full are dropped; tb8 captured with data
    // ninth bit latched with byte
    if (buf_wr && !hfull_q) begin
      hold_d = {cfg_q.tb8, wdat_q[7:0]};
      hfull_d = 1'b1;
    end
    unique case (tst_q)
      T_IDLE: begin
        tph_d = 4'h0;
        tbit_d = 4'h0;
        // frames launch on a tick so the start bit gets a full 16 ticks
        if (hfull_q && (os_tick || cfg_q.mode == MODE_SHIFT)) begin
          hfull_d = 1'b0;
          t0rx_d = 1'b0;
          tsr_d = {1'b1, nine ? hold_q[8] : 1'b1, hold_q[7:0], 1'b0};
          tst_d = cfg_q.mode == MODE_SHIFT ? T_SHIFT0 : T_FRAME;
          ti_set = cfg_q.dbl;
        end else if (cfg_q.mode == MODE_SHIFT && cfg_q.ren && !ri_q) begin
          t0rx_d = 1'b1;
          tst_d = T_SHIFT0;
        end
      end
      T_FRAME: begin
        txd_d = tsr_q[tbit_q];
        // single buffered reads the live ninth bit
        if (tbit_q == NINTH_POS && nine && !cfg_q.dbl) txd_d = cfg_q.tb8;
        if (os_tick) begin
          tph_d = tph_q + 4'h1;
          if (tph_q == PH_LAST) begin
            tbit_d = tbit_q + 4'h1;
            if (tbit_q == (nine ? NB_9 : NB_8)) begin
              // next frame follows straight after one stop bit
              if (hfull_q) begin
                hfull_d = 1'b0;
                tsr_d = {1'b1, nine ? hold_q[8] : 1'b1, hold_q[7:0], 1'b0};
                tbit_d = 4'h0;
                ti_set = cfg_q.dbl;
              end else begin
                tst_d = T_IDLE;
                ti_set = !cfg_q.dbl;
              end
            end
          end
        end
      end
      T_SHIFT0: begin
        // clock low then high each 16 cycles, lsb first
        tph_d = tph_q + 4'h1;
        txd_d = tph_q >= PH_HIGH;
        rxoe_d = t0rx_q;
        rxo_d = tsr_q[1];
        if (tph_q == PH_LAST) begin
          tbit_d = tbit_q + 4'h1;
          if (t0rx_q) tsr_d = {3'h0, rs2_q, tsr_q[7:1]};
          else tsr_d = {1'b1, tsr_q[10:1]};
          if (tbit_q == NB_M0) begin
            tst_d = T_IDLE;
            ti_set = !t0rx_q;
            m0_ri_set = t0rx_q;
          end
        end
      end
    endcase
  end

  // ************************************************
  // receiver and break detector
  // ************************************************
  always_comb begin
    rst_d = rst_q;
    rph_d = rph_q;
    rbit_d = rbit_q;
    rsr_d = rsr_q;
    bcnt_d = bcnt_q;
    rx_done = 1'b0;
    rx_stop = rs2_q;
    rx_data = nine ? rsr_q[7:0] : rsr_q[8:1];
    rx_nb8 = nine ? rsr_q[8] : rs2_q;
    brk_set = 1'b0;
    // count low oversample ticks up to 11 bit times
    if (rs2_q) bcnt_d = 8'h00;
    else if (os_tick && bcnt_q != BRK_TICKS) begin
      bcnt_d = bcnt_q + 8'h01;
      brk_set = bcnt_q == BRK_TICKS - 8'h01;
    end
    if (os_tick && cfg_q.mode != MODE_SHIFT) begin
      rph_d = rph_q + 4'h1;
      unique case (rst_q)
        R_IDLE: begin
          rph_d = 4'h0;
          if (!rs2_q && cfg_q.ren) rst_d = R_START;
        end
        R_START: if (rph_q == PH_MID) begin
          rph_d = 4'h0;
          rbit_d = 4'h0;
          rst_d = rs2_q ? R_IDLE : R_DATA;
        end
        R_DATA: if (rph_q == PH_LAST) begin
          rsr_d = {rs2_q, rsr_q[8:1]};
          rbit_d = rbit_q + 4'h1;
          if (rbit_q == (nine ? RX_NB_9 : RX_NB_8)) rst_d = R_STOP;
        end
        R_STOP: if (rph_q == PH_LAST) begin
          rx_done = 1'b1;
          rst_d = R_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // state registers
  // ************************************************
  always_ff @(posedge aclk) begin
    rs1_q <= rxd_i;
    rs2_q <= rs1_q;
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      bv_q <= 1'b0;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      bresp_q <= RESP_OK;
      rresp_q <= RESP_OK;
      rdata_q <= 32'h00000000;
      wdat_q <= 32'h00000000;
      waddr_q <= OFF_CTRL;
      cfg_q <= CFG_RST;
      divl_q <= 8'h00;
      divh_q <= 8'h00;
      {ti_q, ri_q, rb8_q, fe_q, brk_q, brksrc_q, devrst_q} <= 7'h00;
      rbuf_q <= 8'h00;
      brg_q <= DIV_RST;
      half_q <= 1'b0;
      tst_q <= T_IDLE;
      tsr_q <= 11'h7FF;
      {tph_q, tbit_q, rph_q, rbit_q} <= 16'h0000;
      {t0rx_q, hfull_q} <= 2'h0;
      hold_q <= 9'h000;
      {txd_q, rxo_q, rxoe_q} <= 3'h7;
      rst_q <= R_IDLE;
      rsr_q <= 9'h000;
      bcnt_q <= 8'h00;
    end else begin
      {aw_q, w_q, awr_q, wr_q, bv_q, arr_q, rv_q} <= {aw_d, w_d, awr_d, wr_d, bv_d, arr_d, rv_d};
      {bresp_q, rresp_q, rdata_q, wdat_q, waddr_q} <= {bresp_d, rresp_d, rdata_d, wdat_d, waddr_d};
      {cfg_q, divl_q, divh_q, rbuf_q} <= {cfg_d, divl_d, divh_d, rbuf_d};
      {ti_q, ri_q, rb8_q, fe_q, brk_q, brksrc_q, devrst_q} <= {ti_d, ri_d, rb8_d, fe_d, brk_d, brksrc_d, devrst_d};
      {brg_q, half_q} <= {brg_d, half_d};
      tst_q <= tst_d;
      {tsr_q, tph_q, tbit_q, t0rx_q, hfull_q, hold_q} <= {tsr_d, tph_d, tbit_d, t0rx_d, hfull_d, hold_d};
      {txd_q, rxo_q, rxoe_q} <= {txd_d, rxo_d, rxoe_d};
      rst_q <= rst_d;
      {rph_q, rbit_q, rsr_q, bcnt_q} <= {rph_d, rbit_d, rsr_d, bcnt_d};
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign txd_o = txd_q;
  assign rxd_o = rxo_q;
  assign rxd_oe_n = rxoe_q;
  assign device_reset = devrst_q;

endmodule

// >>> verif/eud_uart_asserts.sv
// checker for the enhanced uart: bus answer timing, frame start, reset pulse
// assumes a bind onto eud_uart, one clock aclk and synchronous aresetn
`timescale 1ns/1ps
module eud_uart_asserts
  import eud_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [eud_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd_o,
  input wire logic rxd_oe_n,
  input wire logic device_reset
);
  // ************************
  // properties
  // ************************
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RD_NEXT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_RD_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RD_ERR: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0)
    else $error("bad read address accepted");
  AST_RD_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_WR_TWO: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not after two cycles");
  AST_WR_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  // a low run on the line is never shorter than half a bit
  AST_START_LOW: assert property (
    $fell(txd_o) |-> !txd_o [*8])
    else $error("short low on tx line");
  AST_RST_PULSE: assert property (
    device_reset |=> !device_reset)
    else $error("device reset not one cycle");
  AST_RST_IDLE: assert property (
    disable iff (1'h0) !aresetn |=> txd_o && rxd_oe_n && !device_reset && !s_axi_bvalid)
    else $error("lines not idle after reset");
endmodule

bind eud_uart eud_uart_asserts eud_uart_asserts_i (.*);

// >>> verif/eud_serial_node.sv
// remote serial node: captures frames from tx line, sends frames on rx line
// assumes bit time in aclk cycles and frame length set by the bench
`timescale 1ns/1ps
module eud_serial_node (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  int bclk = 16;
  int nbits = 8;
  int frames = 0;
  int cyc = 0;
  int st = 0;
  int pst = 0;
  logic [9:0] got_q = 10'h000;
  logic [9:0] pgot = 10'h000;

  // line rests high, as a pulled-up idle line does
  initial rxd = 1'h1;
  // free cycle count for frame spacing
  always @(posedge aclk) cyc <= cyc + 1;
  always begin
    @(negedge txd);
    pst = st;
    st = cyc;
    pgot = got_q;
    repeat (bclk / 2) @(posedge aclk);
    for (int i = 0; i <= nbits; i++) begin
      repeat (bclk) @(posedge aclk);
      got_q[i] = txd;
    end
    frames++;
  end
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bclk) @(posedge aclk);
    end
    rxd <= 1'h1;
  endtask
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the enhanced uart, registers over axi4-lite
// assumes the serial node model on the pins and the bound checker
`timescale 1ns/1ps
module tb_top;
  import eud_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, t1_overflow = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rxd_o, rxd_oe_n, txd_o, device_reset, node_rxd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdv;
  wire logic rxd_i;
  int num_errors = 0;
  int checked = 0;
  int resets = 0;
  logic [7:0] m0_q = 8'h00;

  // shared receive pin: the uart drives it only in shift mode
  assign rxd_i = rxd_oe_n ? node_rxd : rxd_o;
  eud_uart eud_uart_i (.*);
  eud_serial_node eud_serial_node_i (.aclk(aclk), .txd(txd_o), .rxd(node_rxd));

  // 200 MHz clock and a count of reset requests
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (device_reset) resets <= resets + 1;
  end
  // shift-mode capture: data stands still while the shift clock is high
  always @(posedge txd_o) begin
    if (!rxd_oe_n) m0_q <= {rxd_o, m0_q[7:1]};
  end

  // ************************
  // tasks
  // ************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    rd(a);
    chk(nm, {24'h0, rdv[7:0] & m}, {24'h0, e});
  endtask
  task automatic wf(input int k);
    repeat (5000) begin
      @(posedge aclk);
      if (eud_serial_node_i.frames >= k) break;
    end
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    test_done();
  end

  // ************************
  // tests
  // ************************
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rc(OFF_CTRL, 8'hFF, 8'h00, "ctrl reset");
    rc(OFF_STAT, 8'hFF, 8'h00, "stat reset");
    rd(5'h02);
    chk("rresp", resp, RESP_ERR);
    wr(5'h01, 8'hFF);
    chk("bresp", resp, RESP_ERR);
    tend("reset");
    // 8-bit frames on timer 1, rate halved: 32 clocks a bit
    t1_overflow <= 1'h1;
    eud_serial_node_i.bclk = 32;
    wr(OFF_CTRL, 8'h50);
    wr(OFF_BUF, 8'hA5);
    rc(OFF_CTRL, 8'hFF, 8'h50, "tx flag early");
    wf(1);
    chk("tx8", eud_serial_node_i.got_q[8:0], {1'h1, 8'hA5});
    repeat (40) @(posedge aclk);
    rc(OFF_CTRL, 8'hFF, 8'h52, "tx flag");
    eud_serial_node_i.send({1'h1, 8'h3C, 1'h0}, 10);
    repeat (20) @(posedge aclk);
    rc(OFF_BUF, 8'hFF, 8'h3C, "rx8");
    rc(OFF_CTRL, 8'hFF, 8'h57, "stop kept");
    tend("mode1");
    // fixed 9-bit frames at clk/16, ninth bit set before data
    wr(OFF_PWR, 8'h80);
    wr(OFF_CTRL, 8'h98);
    eud_serial_node_i.bclk = 16;
    eud_serial_node_i.nbits = 9;
    wr(OFF_BUF, 8'h5A);
    wf(2);
    chk("tx9", eud_serial_node_i.got_q, {2'h3, 8'h5A});
    eud_serial_node_i.send({2'h2, 8'hC3, 1'h0}, 11);
    repeat (20) @(posedge aclk);
    rc(OFF_BUF, 8'hFF, 8'hC3, "rx9");
    rc(OFF_CTRL, 8'hFF, 8'h9B, "ninth kept");
    tend("mode2");
    // mode 3 on the generator, divisor 1: 32 clocks a bit, double buffered
    wr(OFF_CFG, 8'h01);
    wr(OFF_DIVL, 8'h01);
    wr(OFF_DIVH, 8'h00);
    wr(OFF_STAT, 8'h80);
    eud_serial_node_i.bclk = 32;
    wr(OFF_CTRL, 8'hD8);
    wr(OFF_BUF, 8'h11);
    rc(OFF_CTRL, 8'hFF, 8'hDA, "tx flag at move");
    wr(OFF_CTRL, 8'hD0);
    wr(OFF_BUF, 8'h22);
    rc(OFF_STAT, 8'hFF, 8'h83, "holder full");
    wf(4);
    chk("first", eud_serial_node_i.pgot, {2'h3, 8'h11});
    chk("second", eud_serial_node_i.got_q, {2'h2, 8'h22});
    chk("spacing", eud_serial_node_i.st - eud_serial_node_i.pst, 352);
    tend("double buffer");
    // low stop bit, shown in status and in the control top bit
    eud_serial_node_i.send({2'h1, 8'h77, 1'h0}, 11);
    repeat (20) @(posedge aclk);
    rc(OFF_STAT, 8'h04, 8'h04, "frame err");
    wr(OFF_PWR, 8'h40);
    rc(OFF_CTRL, 8'h80, 8'h80, "err in ctrl");
    wr(OFF_STAT, 8'h80);
    rc(OFF_CTRL, 8'h80, 8'h00, "err cleared");
    wr(OFF_PWR, 8'h00);
    rc(OFF_CTRL, 8'h80, 8'h80, "mode bit");
    tend("frame error");
    // ten low bit times is no break, a longer stretch is
    wr(OFF_CFG, 8'h03);
    eud_serial_node_i.send(11'h000, 10);
    repeat (20) @(posedge aclk);
    rc(OFF_STAT, 8'h08, 8'h00, "no break");
    eud_serial_node_i.bclk = 36;
    eud_serial_node_i.send(11'h000, 11);
    eud_serial_node_i.bclk = 32;
    repeat (20) @(posedge aclk);
    rc(OFF_STAT, 8'h08, 8'h08, "break");
    rc(OFF_RSRC, 8'h01, 8'h01, "break source");
    wr(OFF_RSRC, 8'h00);
    rc(OFF_RSRC, 8'h01, 8'h00, "source cleared");
    chk("reset pulses", resets, 1);
    tend("break");
    // shift mode: buffer off, receiver off, byte out on the receive pin
    wr(OFF_STAT, 8'h00);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_BUF, 8'h96);
    repeat (150) @(posedge aclk);
    chk("shift out", m0_q, 8'h96);
    rc(OFF_CTRL, 8'h02, 8'h02, "shift tx flag");
    tend("shift");
    test_done();
  end
endmodule
